// ---- ecpmc_pkg.sv ----
package ecpmc_pkg;

    // ------------------------------------------------------------
    // Register offsets from the port base address.
    // ------------------------------------------------------------
    localparam logic [10:0] OFS_CMDQ = 11'h000;
    localparam logic [10:0] OFS_FIFO = 11'h400;
    localparam logic [10:0] OFS_CFGB = 11'h401;
    localparam logic [10:0] OFS_ECR  = 11'h402;

    // ------------------------------------------------------------
    // Extended control register layout and reset value.
    // ------------------------------------------------------------
    localparam int          ECR_MODE_LSB = 5;
    localparam int          ECR_FDIS     = 4;
    localparam int          ECR_DMA      = 3;
    localparam int          ECR_SVC      = 2;
    localparam int          ECR_FULL     = 1;
    localparam int          ECR_EMPTY    = 0;
    localparam logic [7:0]  ECR_RESET    = 8'h14;
    localparam logic [7:0]  CFGA_VALUE   = 8'h10;

    // ------------------------------------------------------------
    // FIFO geometry and timing.
    // ------------------------------------------------------------
    localparam int          FIFO_DEPTH   = 16;
    localparam int          CLK_NS       = 10;
    localparam int          IRQ_PULSE_NS = 100;
    localparam int          STROBE_NS    = 500;
    localparam int          SETUP_NS     = 500;
    localparam logic [7:0]  IRQ_CYC      = 8'(IRQ_PULSE_NS / CLK_NS);
    localparam logic [7:0]  STROBE_CYC   = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0]  SETUP_CYC    = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [14:0] SYNC_RESET   = 15'h7FFF;

    typedef enum logic [2:0] {
        MODE_STD   = 3'b000,
        MODE_BIDIR = 3'b001,
        MODE_CFIFO = 3'b010,
        MODE_ECP   = 3'b011,
        MODE_EPP   = 3'b100,
        MODE_RSVD  = 3'b101,
        MODE_TEST  = 3'b110,
        MODE_CFG   = 3'b111
    } ecpmc_mode_t;

    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } ecpmc_entry_t;

endpackage

// ---- ecpmc_top.sv ----
// What this block does
// - Three-bit mode field selects port mode.
// - Fault falling edge or re-enable interrupts.
// - DMA runs only when allowed and unmasked.
// - Mask set blocks DMA and service interrupts.
// - Service interrupt sets mask; software clears.
// - DMA terminal count sets the mask.
// - Forward: free space reaching threshold interrupts.
// - Reverse: fill reaching threshold interrupts.
// - Read-only full and empty status bits.
// - Standard mode: FIFO reset, open-collector controls.
// - Bidirectional: direction tri-states data, push-pull.
// - Compatible FIFO mode sends with printer handshake.
// - ECP forward shares FIFO; reverse fills FIFO.
// - Mode 100 EPP only when enabled.
// - Test mode: FIFO free access, no handshake.
// - Configuration mode maps config word A at FIFO, config word B at the next address.
// - Config word B reports IRQ and DMA codes.
// - Extended modes switch only back to standard or bidirectional.
// - Entering FIFO or ECP mode starts transfers.
// - Leaving mode deasserts lines, discards bytes.
// - ECP reverse handshakes bytes to fill FIFO.
// - Service interrupt is brief low pulse, shared.
// - Effective threshold is programmed value plus one.
`timescale 1ns/10ps
`default_nettype none
module ecpmc_top
    import ecpmc_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic        SEL_I,
    input  wire logic [10:0] ADDR_I,
    input  wire logic        IOR_N_I,
    input  wire logic        IOW_N_I,
    input  wire logic [7:0]  DATA_I,
    output logic      [7:0]  DATA_O,
    output logic             DATA_OE_O,
    input  wire logic        DACK_N_I,
    input  wire logic        TC_I,
    output logic             DRQ_O,
    output logic             INTR_O,
    output logic             INTR_OE_O,
    input  wire logic        DIRECTION_I,
    input  wire logic [3:0]  DCR_CTRL_I,
    input  wire logic [7:0]  DATA_REG_I,
    output logic      [7:0]  DATA_READ_O,
    input  wire logic [3:0]  IRQ_SEL_I,
    input  wire logic [1:0]  DMA_SEL_I,
    input  wire logic        EPP_ENABLE_CONFIG_I,
    input  wire logic [3:0]  THRESHOLD_SETTING_I,
    output logic             EPP_ACTIVE_O,
    input  wire logic        FAULT_INPUT_LOW_I,
    input  wire logic        BUSY_I,
    input  wire logic        ACK_LOW_I,
    input  wire logic [7:0]  PD_I,
    output logic      [7:0]  PD_O,
    output logic             PD_OE_O,
    output logic      [3:0]  CTRL_O,
    output logic      [3:0]  CTRL_OE_O
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RX_REQ, ST_RX_ACK
    } ecpmc_state_t;

    logic [14:0]  s1_q, s2_q;
    logic [2:0]   edge_q;
    ecpmc_mode_t  mode_q;
    logic         fdis_q, dma_q, svc_q;
    ecpmc_entry_t mem [FIFO_DEPTH];
    logic [3:0]   wp_q, rp_q;
    logic [4:0]   cnt_q;
    ecpmc_state_t st_q;
    logic [7:0]   tmr_q, irq_q, dout_q, pd_q, rdreg_q;
    logic         cmd_q, oe_q;

    // Every bus control and printer pin passes two flops; the third stage only serves edges.
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            s1_q   <= SYNC_RESET;
            s2_q   <= SYNC_RESET;
            edge_q <= 3'h7;
        end
        else
        begin
            s1_q   <= {IOW_N_I, IOR_N_I, DACK_N_I, TC_I, FAULT_INPUT_LOW_I,
                       BUSY_I, ACK_LOW_I, PD_I};
            s2_q   <= s1_q;
            edge_q <= {s2_q[14:13], s2_q[10]};
        end
    end

    wire       iow_n   = s2_q[14];
    wire       ior_n   = s2_q[13];
    wire       dack    = ~s2_q[12];
    wire       tc      = s2_q[11];
    wire       fault_n = s2_q[10];
    wire       busy    = s2_q[9];
    wire       ack_n   = s2_q[8];
    wire [7:0] pd_in   = s2_q[7:0];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Address and data are held for the whole strobe, so sampling them
    // at the synchronised edge is safe without their own flops.
    wire wr_ev   = edge_q[2] & ~iow_n;
    wire rd_ev   = edge_q[1] & ~ior_n;
    wire is_cfg  = (mode_q == MODE_CFG);
    wire fwd     = ~DIRECTION_I;
    wire fifo_md = (mode_q == MODE_CFIFO) | (mode_q == MODE_ECP)
                 | (mode_q == MODE_TEST);
    wire auto_md = (mode_q == MODE_CFIFO) | (mode_q == MODE_ECP);
    wire at_fifo = SEL_I & ~dack & (ADDR_I == OFS_FIFO);
    wire at_cfgb = SEL_I & ~dack & (ADDR_I == OFS_CFGB);
    wire at_ecr  = SEL_I & ~dack & (ADDR_I == OFS_ECR);
    wire at_cmdq = SEL_I & ~dack & (ADDR_I == OFS_CMDQ);
    wire full    = (cnt_q == 5'(FIFO_DEPTH));
    wire empty   = (cnt_q == 5'h00);
    wire [4:0] thr  = {1'b0, THRESHOLD_SETTING_I} + 5'h01;
    wire [4:0] free = 5'(FIFO_DEPTH) - cnt_q;

    // Host FIFO access, by address or by DMA acknowledge.
    wire host_wr = wr_ev & ((dack | (at_fifo & ~is_cfg))
                 & ((mode_q == MODE_CFIFO) | (mode_q == MODE_TEST)
                 | ((mode_q == MODE_ECP) & fwd)));
    wire cmd_wr  = wr_ev & at_cmdq & (mode_q == MODE_ECP) & fwd;
    wire host_rd = rd_ev & (dack | (at_fifo & ~is_cfg))
                 & ((mode_q == MODE_TEST) | ((mode_q == MODE_ECP) & ~fwd));
    wire ecr_wr  = wr_ev & at_ecr;

    // ------------------------------------------------------------
    // Extended control register
    // ------------------------------------------------------------
    wire [2:0] new_mode = DATA_I[ECR_MODE_LSB +: 3];
    wire mode_ok = (mode_q == MODE_STD) | (mode_q == MODE_BIDIR)
                 | (new_mode == MODE_STD) | (new_mode == MODE_BIDIR);
    wire fifo_clr = (mode_q == MODE_STD) | (mode_q == MODE_BIDIR);

    // Service condition; the mask blocks it and hardware then sets it.
    wire tc_ev   = dack & tc & (wr_ev | rd_ev);
    wire svc_ev  = fifo_md & ~svc_q & (dma_q ? tc_ev
                 : (fwd ? (free >= thr) : (cnt_q >= thr)));
    wire fall_ev = (mode_q == MODE_ECP) & ~fdis_q & edge_q[0] & ~fault_n;
    wire fen_ev  = ecr_wr & (mode_q == MODE_ECP) & fdis_q
                 & ~DATA_I[ECR_FDIS] & ~fault_n;
    wire irq_go  = svc_ev | fall_ev | fen_ev;

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            mode_q <= MODE_STD;
            fdis_q <= ECR_RESET[ECR_FDIS];
            dma_q  <= ECR_RESET[ECR_DMA];
            svc_q  <= ECR_RESET[ECR_SVC];
        end
        else
        begin
            if (ecr_wr & mode_ok)
                mode_q <= ecpmc_mode_t'(new_mode);
            if (ecr_wr)
            begin
                fdis_q <= DATA_I[ECR_FDIS];
                dma_q  <= DATA_I[ECR_DMA];
            end
            if (svc_ev)
                svc_q <= 1'b1;
            else if (ecr_wr)
                svc_q <= DATA_I[ECR_SVC];
        end
    end

    // DMA asks while the FIFO can move a byte in the current direction.
    assign DRQ_O = fifo_md & dma_q & ~svc_q
                 & (fwd ? ~full : ~empty);
    assign EPP_ACTIVE_O = (mode_q == MODE_EPP) & EPP_ENABLE_CONFIG_I;

    // ------------------------------------------------------------
    // Port handshake engine
    // ------------------------------------------------------------
    wire tx_start = (st_q == ST_IDLE) & auto_md & fwd & ~empty & ~busy;
    wire rx_take  = (st_q == ST_RX_REQ) & ~ack_n & ~full;
    wire port_pop = tx_start;
    wire port_push = rx_take & busy;
    wire do_push  = (host_wr | cmd_wr) & ~full | port_push;
    wire do_pop   = host_rd & ~empty | port_pop;
    ecpmc_entry_t push_e;
    assign push_e = port_push ? '{1'b0, pd_in} : '{cmd_wr, DATA_I};

    // Leaving an automatic mode drops the engine at once, which also
    // releases line feed in the middle of a reverse byte.
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_q  <= ST_IDLE;
            tmr_q <= 8'h00;
            pd_q  <= 8'h00;
            cmd_q <= 1'b0;
        end
        else if (~auto_md)
            st_q  <= ST_IDLE;
        else
        begin
            tmr_q <= (tmr_q != 8'h00) ? tmr_q - 8'h01 : 8'h00;
            case (st_q)
                ST_IDLE:
                begin
                    if (tx_start)
                    begin
                        pd_q  <= mem[rp_q].data;
                        cmd_q <= mem[rp_q].cmd;
                        tmr_q <= SETUP_CYC;
                        st_q  <= ST_SETUP;
                    end
                    else if ((mode_q == MODE_ECP) & ~fwd & ~full)
                        st_q  <= ST_RX_REQ;
                end
                ST_SETUP:
                    if (tmr_q == 8'h00)
                    begin
                        tmr_q <= STROBE_CYC;
                        st_q  <= ST_STROBE;
                    end
                ST_STROBE:
                    if ((mode_q == MODE_ECP) ? busy : (tmr_q == 8'h00))
                        st_q <= ST_HOLD;
                ST_HOLD:
                    if (~busy)
                        st_q <= ST_IDLE;
                ST_RX_REQ:
                    if (rx_take)
                        st_q <= ST_RX_ACK;
                ST_RX_ACK:
                    if (ack_n)
                        st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // FIFO store
    // ------------------------------------------------------------
    // Test mode never stalls: a full write is dropped, an empty read
    // returns the last byte again.
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wp_q  <= 4'h0;
            rp_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else if (fifo_clr)
        begin
            wp_q  <= 4'h0;
            rp_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else
        begin
            if (do_push)
                wp_q <= wp_q + 4'h1;
            if (do_pop)
                rp_q <= rp_q + 4'h1;
            cnt_q <= cnt_q + {4'h0, do_push} - {4'h0, do_pop};
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (do_push)
            mem[wp_q] <= push_e;
    end

    // ------------------------------------------------------------
    // Read data and configuration words
    // ------------------------------------------------------------
    logic [2:0] irq_code, dma_code;
    always_comb
    begin
        case (IRQ_SEL_I)
            4'hF:    irq_code = 3'h6;
            4'hE:    irq_code = 3'h5;
            4'hB:    irq_code = 3'h4;
            4'hA:    irq_code = 3'h3;
            4'h9:    irq_code = 3'h2;
            4'h7:    irq_code = 3'h1;
            4'h5:    irq_code = 3'h7;
            default: irq_code = 3'h0;
        endcase
        case (DMA_SEL_I)
            2'h3:    dma_code = 3'h3;
            2'h2:    dma_code = 3'h2;
            2'h1:    dma_code = 3'h1;
            default: dma_code = 3'h0;
        endcase
    end

    wire [7:0] ecr_rd  = {mode_q, fdis_q, dma_q, svc_q, full, empty};
    wire [7:0] cfgb_rd = {1'b0, ~INTR_OE_O, irq_code, dma_code};
    wire [7:0] fifo_rd = empty ? mem[rp_q - 4'h1].data : mem[rp_q].data;
    wire [7:0] rd_mux  = at_ecr ? ecr_rd
                       : (is_cfg & at_fifo) ? CFGA_VALUE
                       : (is_cfg & at_cfgb) ? cfgb_rd : fifo_rd;
    wire       rd_hit  = at_ecr | at_fifo | dack | (is_cfg & at_cfgb);

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            dout_q  <= 8'h00;
            oe_q    <= 1'b0;
            rdreg_q <= 8'h00;
        end
        else
        begin
            if (rd_ev)
                dout_q <= rd_mux;
            oe_q    <= ~ior_n & rd_hit;
            rdreg_q <= (mode_q == MODE_BIDIR) ? pd_in : DATA_REG_I;
        end
    end
    assign DATA_O      = dout_q;
    assign DATA_OE_O   = oe_q;
    assign DATA_READ_O = rdreg_q;

    // ------------------------------------------------------------
    // Interrupt pulse and pins
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
            irq_q <= 8'h00;
        else if (irq_go)
            irq_q <= IRQ_CYC;
        else if (irq_q != 8'h00)
            irq_q <= irq_q - 8'h01;
    end
    assign INTR_O    = 1'b0;
    assign INTR_OE_O = (irq_q != 8'h00);

    // Control order: strobe, line feed, init, select (all active low).
    wire strobe_low = (st_q == ST_STROBE);
    wire lf_low     = (st_q == ST_RX_REQ)
                    | ((mode_q == MODE_ECP) & cmd_q & (st_q != ST_IDLE));
    wire [3:0] ctl  = auto_md ? {DCR_CTRL_I[3:2], ~lf_low, ~strobe_low}
                              : DCR_CTRL_I;
    assign CTRL_O    = ctl;
    assign CTRL_OE_O = (mode_q == MODE_STD) ? ~ctl : 4'hF;
    assign PD_O      = auto_md ? pd_q : DATA_REG_I;
    assign PD_OE_O   = (mode_q == MODE_STD) | (mode_q == MODE_CFIFO)
                     | fwd;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    mode_guard_a: assert property (ecr_wr & ~mode_ok |=> $stable(mode_q))
        else $error("illegal mode switch taken");
    mask_set_a: assert property (svc_ev |=> svc_q)
        else $error("mask not set after service");
    tc_mask_a: assert property (fifo_md & dma_q & ~svc_q & tc_ev |=> svc_q)
        else $error("terminal count did not mask");
    dma_gate_a: assert property (DRQ_O |-> dma_q & ~svc_q)
        else $error("DMA request while gated");
    irq_pulse_a: assert property ($rose(INTR_OE_O) |-> INTR_OE_O[*8]
        ##1 INTR_OE_O ##1 INTR_OE_O)
        else $error("interrupt pulse length wrong");
    fault_irq_a: assert property (fall_ev |=> INTR_OE_O)
        else $error("fault edge gave no pulse");
    fifo_clr_a: assert property (mode_q == MODE_STD |=> empty)
        else $error("FIFO not held empty");
    flags_a: assert property (~(full & empty) && cnt_q <= 5'(FIFO_DEPTH))
        else $error("FIFO flags inconsistent");
    leave_a: assert property (~auto_md |=> CTRL_O[1:0] == DCR_CTRL_I[1:0]
        || auto_md) else $error("lines kept after leaving");
    svc_fwd_a: assert property (fifo_md & ~svc_q & ~dma_q & fwd
        & (free >= thr) |=> svc_q)
        else $error("threshold did not mask");

    tx_cov: cover property (st_q == ST_STROBE ##[1:200] st_q == ST_IDLE);
    rx_cov: cover property (port_push);
    tc_cov: cover property (tc_ev & dma_q);
    cfg_cov: cover property (rd_ev & is_cfg & at_cfgb);

endmodule
`default_nettype wire

// ---- ecpmc_printer.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Printer on the far side of the port.
// ----------------------------------------
module ecpmc_printer
(
    input  wire logic       clk_i,
    input  wire logic [3:0] ctrl_i,
    input  wire logic [7:0] pd_i,
    input  wire logic       pd_oe_i,
    output logic            busy_o,
    output logic            ack_low_o,
    output logic      [7:0] pd_o
);
    logic [8:0] rx_q[$];
    logic [7:0] tx_q[$];
    int         slow;
    int         n;

    task automatic pause(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_high(input int b);
        for (n = 0; n < 2000 && ctrl_i[b] !== 1'b1; n++)
            pause(1);
    endtask

    // One byte at a time; a released bus shows the inverted last byte so
    // that stale data can never pass for a fresh one.
    initial
    begin
        busy_o = 1'b0;
        ack_low_o = 1'b1;
        pd_o = 8'hA5;
        slow = 0;
        forever
        begin
            pause(1);
            if (ctrl_i[0] === 1'b0 && pd_oe_i === 1'b1)
            begin
                rx_q.push_back({ctrl_i[1], pd_i});
                pause(1 + slow);
                busy_o = 1'b1;
                wait_high(0);
                pause(1 + slow);
                busy_o = 1'b0;
            end
            else if (ctrl_i[1] === 1'b0 && pd_oe_i === 1'b0 && tx_q.size() > 0)
            begin
                pd_o = tx_q.pop_front();
                busy_o = 1'b1;
                pause(1 + slow);
                ack_low_o = 1'b0;
                wait_high(1);
                ack_low_o = 1'b1;
                pause(1);
                busy_o = 1'b0;
                pd_o = ~pd_o;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Self-checking bench for the port block.
// ----------------------------------------
module testbench import ecpmc_pkg::*;;
    typedef struct {string name; logic [8:0] val;} ecpmc_note_t;
    localparam logic [3:0] IRQS [8] = '{4'hF, 4'hE, 4'hB, 4'hA, 4'h9,
                                        4'h7, 4'h5, 4'h3};
    localparam logic [2:0] CODES [8] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2,
                                         3'h1, 3'h7, 3'h0};
    logic        CLOCK_I, RST_I, SEL_I, IOR_N_I, IOW_N_I, DACK_N_I, TC_I;
    logic        DIRECTION_I, EPP_ENABLE_CONFIG_I, FAULT_INPUT_LOW_I;
    logic        BUSY_I, ACK_LOW_I, DATA_OE_O, DRQ_O, INTR_O, INTR_OE_O;
    logic        EPP_ACTIVE_O, PD_OE_O, oe_q;
    logic [10:0] ADDR_I;
    logic [7:0]  DATA_I, DATA_O, DATA_REG_I, DATA_READ_O, PD_I, PD_O, pd_far;
    logic [3:0]  DCR_CTRL_I, IRQ_SEL_I, THRESHOLD_SETTING_I;
    logic [3:0]  CTRL_O, CTRL_OE_O;
    logic [1:0]  DMA_SEL_I;
    logic [15:0] rnd;
    logic [8:0]  ref_q[$];
    ecpmc_note_t note_q[$], prn_q[$], nt;
    int          mismatches, samples_checked, irq_cnt, irq_exp, irq_len, i;

    assign PD_I = PD_OE_O ? PD_O : pd_far;

    ecpmc_top dut_u (.*);

    ecpmc_printer prt_u (.clk_i(CLOCK_I), .ctrl_i(CTRL_O), .pd_i(PD_I),
        .pd_oe_i(PD_OE_O), .busy_o(BUSY_I), .ack_low_o(ACK_LOW_I),
        .pd_o(pd_far));

    always #5 CLOCK_I = ~CLOCK_I;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic tick;
        @(posedge CLOCK_I);
        #1;
    endtask

    task automatic check(input string n, input logic [8:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Strobes stay low six cycles and high six, well above the minimum.
    task automatic io(input logic [10:0] a, input logic [7:0] d,
                      input logic rd, dma, tc);
        tick;
        SEL_I = !dma;
        DACK_N_I = !dma;
        {ADDR_I, DATA_I, TC_I} = {a, d, tc};
        if (rd)
            IOR_N_I = 1'b0;
        else
            IOW_N_I = 1'b0;
        repeat (6) tick;
        {IOR_N_I, IOW_N_I} = 2'h3;
        repeat (6) tick;
        {SEL_I, DACK_N_I, TC_I} = 3'h2;
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        io(a, d, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [10:0] a, input logic [7:0] e, string n);
        note_q.push_back('{n, {1'b0, e}});
        io(a, 8'h00, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic send(input logic cmd, input logic [7:0] d);
        prn_q.push_back('{"printer byte", {!cmd, d}});
        wr(cmd ? OFS_CMDQ : OFS_FIFO, d);
    endtask

    task automatic settle;
        for (int k = 0; k < 3000 && prn_q.size() + prt_u.tx_q.size() > 0; k++)
            tick;
        repeat (40) tick;
    endtask

    task automatic irq_chk(input string n);
        repeat (20) tick;
        check(n, 9'(irq_cnt), 9'(irq_exp));
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Each result that shows up takes the oldest note of its kind.
    always @(negedge CLOCK_I)
    begin
        oe_q <= DATA_OE_O;
        if (DATA_OE_O === 1'b1 && oe_q !== 1'b1)
        begin
            nt = note_q.pop_front();
            check(nt.name, {1'b0, DATA_O}, nt.val);
        end
        if (prt_u.rx_q.size() > 0)
        begin
            nt = prn_q.pop_front();
            check(nt.name, prt_u.rx_q.pop_front(), nt.val);
        end
        if (INTR_OE_O === 1'b1)
            irq_len += (INTR_O === 1'b0) ? 1 : 100;
        else if (irq_len > 0)
        begin
            check("irq pulse", 9'(irq_len), 9'(IRQ_CYC));
            irq_cnt++;
            irq_len = 0;
        end
    end

    // A hang is cut short long after the sequence should have ended.
    initial
    begin
        repeat (40000) @(posedge CLOCK_I);
        mismatches++;
        close_out;
    end

    initial
    begin
        rnd = 16'hCCEE;
        {CLOCK_I, SEL_I, TC_I, DIRECTION_I, EPP_ENABLE_CONFIG_I, oe_q} = '0;
        {RST_I, IOR_N_I, IOW_N_I, DACK_N_I, FAULT_INPUT_LOW_I} = '1;
        {ADDR_I, DATA_I, DATA_REG_I} = {11'h000, 8'h00, rnd[7:0]};
        {DCR_CTRL_I, IRQ_SEL_I, DMA_SEL_I} = {4'hF, 4'hF, 2'h3};
        THRESHOLD_SETTING_I = 4'h3;
        repeat (10) @(posedge CLOCK_I);
        #1 RST_I = 1'b0;
        repeat (4) tick;
        rd(OFS_ECR, 8'h15, "ecr after reset");
        DCR_CTRL_I = 4'h5;
        repeat (2) tick;
        check("control enables", {5'h00, CTRL_OE_O}, 9'h00A);
        check("data port", {1'b0, DATA_READ_O}, {1'b0, DATA_REG_I});
        DCR_CTRL_I = 4'hF;
        wr(OFS_ECR, 8'hF4);
        for (i = 0; i < 8; i++)
        begin
            {IRQ_SEL_I, DMA_SEL_I} = {IRQS[i], i[1:0]};
            rd(OFS_CFGB, {2'h1, CODES[i], 1'b0, i[1:0]}, "config b");
        end
        rd(OFS_FIFO, 8'h10, "config a");
        wr(OFS_ECR, 8'hD8);
        rd(OFS_ECR, 8'hF9, "mode kept");
        wr(OFS_ECR, 8'h14);
        for (i = 0; i < 2; i++)
        begin
            EPP_ENABLE_CONFIG_I = i[0];
            wr(OFS_ECR, 8'h94);
            check("epp active", {8'h00, EPP_ACTIVE_O}, 9'(i));
            wr(OFS_ECR, 8'h14);
        end
        // Test mode: fill past full, then drain past empty.
        wr(OFS_ECR, 8'h34);
        DIRECTION_I = 1'b1;
        wr(OFS_ECR, 8'hD4);
        for (i = 0; i < 17; i++)
        begin
            rnd = lfsr(rnd);
            ref_q.push_back({1'b0, rnd[7:0]});
            wr(OFS_FIFO, rnd[7:0]);
        end
        rd(OFS_ECR, 8'hD6, "ecr full");
        for (i = 0; i < 17; i++)
            rd(OFS_FIFO, ref_q[i < 16 ? i : 15][7:0], "test fifo");
        rd(OFS_ECR, 8'hD5, "ecr empty");
        // A programmed three means the fourth byte interrupts.
        wr(OFS_ECR, 8'hD0);
        for (i = 0; i < 4; i++)
        begin
            irq_chk("early irq");
            wr(OFS_FIFO, rnd[15:8]);
        end
        irq_exp++;
        irq_chk("fill irq");
        rd(OFS_ECR, 8'hD4, "mask set");
        wr(OFS_ECR, 8'h34);
        DIRECTION_I = 1'b0;
        wr(OFS_ECR, 8'hD4);
        wr(OFS_ECR, 8'hD0);
        irq_exp++;
        irq_chk("free irq");
        wr(OFS_ECR, 8'hDC);
        check("drq masked", {8'h00, DRQ_O}, 9'h000);
        wr(OFS_ECR, 8'hD8);
        check("drq allowed", {8'h00, DRQ_O}, 9'h001);
        io(OFS_CMDQ, rnd[15:8], 1'b0, 1'b1, 1'b0);
        io(OFS_CMDQ, rnd[7:0], 1'b0, 1'b1, 1'b1);
        irq_exp++;
        irq_chk("tc irq");
        check("drq after tc", {8'h00, DRQ_O}, 9'h000);
        rd(OFS_ECR, 8'hDC, "tc mask");
        // Printer transfers, prompt and slow, then command and data.
        wr(OFS_ECR, 8'h14);
        wr(OFS_ECR, 8'h54);
        for (i = 0; i < 4; i++)
        begin
            prt_u.slow = i * 10;
            rnd = lfsr(rnd);
            send(1'b0, rnd[7:0]);
        end
        settle;
        wr(OFS_ECR, 8'h14);
        wr(OFS_ECR, 8'h74);
        send(1'b1, 8'h85);
        send(1'b0, rnd[15:8]);
        settle;
        wr(OFS_ECR, 8'h64);
        FAULT_INPUT_LOW_I = 1'b0;
        irq_exp++;
        irq_chk("fault edge");
        wr(OFS_ECR, 8'h74);
        wr(OFS_ECR, 8'h64);
        irq_exp++;
        irq_chk("fault reenable");
        FAULT_INPUT_LOW_I = 1'b1;
        // Reverse transfer, then leave with one byte unread.
        wr(OFS_ECR, 8'h34);
        DIRECTION_I = 1'b1;
        repeat (3) tick;
        check("pins read", {1'b0, DATA_READ_O}, {1'b0, PD_I});
        check("data released", {8'h00, PD_OE_O}, 9'h000);
        prt_u.slow = 0;
        for (i = 0; i < 3; i++)
            prt_u.tx_q.push_back(8'hC0 ^ i[7:0]);
        wr(OFS_ECR, 8'h74);
        settle;
        rd(OFS_FIFO, 8'hC0, "reverse byte");
        rd(OFS_FIFO, 8'hC1, "reverse byte");
        wr(OFS_ECR, 8'h34);
        check("line feed", {8'h00, CTRL_O[1]}, 9'h001);
        rd(OFS_ECR, 8'h35, "unread dropped");
        DIRECTION_I = 1'b0;
        repeat (4) tick;
        close_out;
    end
endmodule
`default_nettype wire
